//--- rtl/adcpf_consts.vh
`ifndef ADCPF_CONSTS_VH
`define ADCPF_CONSTS_VH

// register byte offsets on the bus
`define ADCPF_OFF_CFG0        8'h00
`define ADCPF_OFF_CFG1        8'h04
`define ADCPF_OFF_P2DIR       8'h08
`define ADCPF_OFF_P7DIR       8'h0c
`define ADCPF_OFF_OPAMP0      8'h10
`define ADCPF_OFF_CHSEL       8'h14
`define ADCPF_OFF_ROLE        8'h18
`define ADCPF_OFF_STATUS      8'h1c

// register reset values
`define ADCPF_RST_CFG0        8'h00
`define ADCPF_RST_CFG1        3'h7
`define ADCPF_RST_P2DIR       8'hff
`define ADCPF_RST_P7DIR       3'h7
`define ADCPF_RST_CHSEL       5'h00

// field positions in the op-amp 0 control register
`define ADCPF_BIT_OPAMP0_EN   7
`define ADCPF_BIT_GAIN_EN     6

// shared pin position in port 2
`define ADCPF_SHARED_BIT      1

// converter channel codes
`define ADCPF_CH_ANALOG1      5'h01
`define ADCPF_CH_GAIN_OUT     5'h10

// pin role codes
`define ADCPF_ROLE_DIN        3'h0
`define ADCPF_ROLE_DOUT       3'h1
`define ADCPF_ROLE_AIN        3'h2
`define ADCPF_ROLE_GAIN_IN    3'h3
`define ADCPF_ROLE_OPAMP_OUT  3'h4
`define ADCPF_ROLE_OPAMP_GAIN 3'h5
`define ADCPF_ROLE_PROHIBIT   3'h7

// bus responses
`define ADCPF_RESP_OKAY       2'b00
`define ADCPF_RESP_SLVERR     2'b10

// status register field positions
`define ADCPF_ST_GAIN_CONV    9
`define ADCPF_ST_PROHIB_ANY   10
`define ADCPF_ST_PROHIB_LSB   11

`endif

//--- rtl/adcpf_decode.v
`timescale 1ns/1ps
`include "adcpf_consts.vh"

module adcpf_decode (
   input  wire [7:0]  cfg0,
   input  wire [2:0]  cfg1,
   input  wire [7:0]  p2dir,
   input  wire [2:0]  p7dir,
   input  wire        opamp0_enable,
   input  wire        gain_amp_enable,
   input  wire [4:0]  chsel,
   output wire [26:0] role,
   output wire [8:0]  conv,
   output reg         gain_conv,
   output wire [8:0]  prohib
);

   localparam SB = `ADCPF_SHARED_BIT;

   reg  [2:0] shared_role;
   reg        shared_conv;

   // shared op-amp / gain-amp pin, slot 0
   always @* begin
      shared_role = `ADCPF_ROLE_PROHIBIT;
      shared_conv = 1'b0;
      gain_conv   = 1'b0;
      if (cfg0[SB]) begin
         if (p2dir[SB]) begin
            case ({opamp0_enable, gain_amp_enable})
               2'b00:   shared_role = `ADCPF_ROLE_AIN;
               2'b01:   shared_role = `ADCPF_ROLE_GAIN_IN;
               2'b10:   shared_role = `ADCPF_ROLE_OPAMP_OUT;
               default: shared_role = `ADCPF_ROLE_OPAMP_GAIN;
            endcase
            shared_conv = (chsel == `ADCPF_CH_ANALOG1);
            gain_conv   = gain_amp_enable && (chsel == `ADCPF_CH_GAIN_OUT);
         end
      end else if (!opamp0_enable && chsel != `ADCPF_CH_ANALOG1) begin
         shared_role = p2dir[SB] ? `ADCPF_ROLE_DIN : `ADCPF_ROLE_DOUT;
      end
   end

   // each slot drives only its own bits of the packed outputs
   assign role[2:0] = shared_role;
   assign conv[0]   = shared_conv;

   // port 2 channel pins 3 to 7 in slots 1 to 5, port 7 pins in slots 6 to 8
   genvar i;
   generate
      for (i = 0; i < 5; i = i + 1) begin : g_p2
         localparam integer CHN = i + 3;
         reg  [2:0] slot_role;
         reg        slot_conv;
         always @* begin
            slot_role = `ADCPF_ROLE_PROHIBIT;
            slot_conv = 1'b0;
            if (cfg0[i+3]) begin
               if (p2dir[i+3]) begin
                  slot_role = `ADCPF_ROLE_AIN;
                  slot_conv = (chsel == CHN[4:0]);
               end
            end else if (chsel != CHN[4:0]) begin
               slot_role = p2dir[i+3] ? `ADCPF_ROLE_DIN : `ADCPF_ROLE_DOUT;
            end
         end
         assign role[3*i+5 -: 3] = slot_role;
         assign conv[i+1]        = slot_conv;
      end
      for (i = 0; i < 3; i = i + 1) begin : g_p7
         localparam integer CHN = i + 8;
         reg  [2:0] slot_role;
         reg        slot_conv;
         always @* begin
            slot_role = `ADCPF_ROLE_PROHIBIT;
            slot_conv = 1'b0;
            if (cfg1[i]) begin
               if (chsel != CHN[4:0])
                  slot_role = p7dir[i] ? `ADCPF_ROLE_DIN : `ADCPF_ROLE_DOUT;
            end else if (p7dir[i]) begin
               slot_role = `ADCPF_ROLE_AIN;
               slot_conv = (chsel == CHN[4:0]);
            end
         end
         assign role[3*i+20 -: 3] = slot_role;
         assign conv[i+6]         = slot_conv;
      end
      for (i = 0; i < 9; i = i + 1) begin : g_pr
         assign prohib[i] = (role[3*i+2 -: 3] == `ADCPF_ROLE_PROHIBIT);
      end
   endgenerate

endmodule // adcpf_decode

//--- rtl/adcpf_top.v
// How it works
// - the op-amp 0 enable is bit 7 of the op-amp 0 control register.
// - the gain-amplifier enable is bit 6 of that same register.
// - shared pin analog, input, both amps off: analog input, converted on channel 1; output is prohibited.
// - gain amp only: pin feeds the amp, amp output or pin converted by channel, else nothing.
// - op-amp 0 only: pin carries the op-amp output, converted only on channel 1.
// - both amps on: pin is op-amp output and amp input, amp or pin converted by channel.
// - port 2 channel pins 3 to 7 analog and input give an analog input, output prohibited.
// - port 7 channel pins 8 to 10 use inverted configuration polarity.
// - port 7 pins take configuration from register 1 and direction from port 7 mode.
// - port 2 pins take configuration from register 0 and direction from port 2 mode.
// - a direction bit of 0 is output, 1 is input.
`timescale 1ns/1ps
`include "adcpf_consts.vh"

module adcpf_top #(
   parameter ADDR_W = 8
) (
   input  wire              aclk,
   input  wire              aresetn,
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire [2:0]        s_axi_awprot,
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire [2:0]        s_axi_arprot,
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   output reg  [26:0]       pin_role,
   output reg  [8:0]        pin_convert,
   output reg               gain_amp_convert,
   output reg  [8:0]        pin_prohibited,
   output reg               setting_prohibited
);

   // control registers
   reg  [7:0]        analog_config_reg_0;
   reg  [2:0]        analog_config_reg_1;
   reg  [7:0]        port2_direction_reg;
   reg  [2:0]        port7_direction_reg;
   reg               opamp0_enable;
   reg               gain_amp_enable;
   reg  [4:0]        converter_channel_select;

   // latched write address and data
   reg  [ADDR_W-1:0] wr_addr;
   reg  [31:0]       wr_data;
   reg  [3:0]        wr_strb;

   // combinational decode results
   wire [26:0]       next_role;
   wire [8:0]        next_conv;
   wire              next_gain_conv;
   wire [8:0]        next_prohib;

   wire              wr_fire;
   wire              wr_mapped;
   wire              rd_mapped;
   reg  [31:0]       rd_word;
   wire [31:0]       status_word;

   // pin function decoder
   adcpf_decode u_decode (
      .cfg0            (analog_config_reg_0),
      .cfg1            (analog_config_reg_1),
      .p2dir           (port2_direction_reg),
      .p7dir           (port7_direction_reg),
      .opamp0_enable   (opamp0_enable),
      .gain_amp_enable (gain_amp_enable),
      .chsel           (converter_channel_select),
      .role            (next_role),
      .conv            (next_conv),
      .gain_conv       (next_gain_conv),
      .prohib          (next_prohib)
   );

   // registered pin role outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_role           <= 27'h0;
         pin_convert        <= 9'h000;
         gain_amp_convert   <= 1'b0;
         pin_prohibited     <= 9'h000;
         setting_prohibited <= 1'b0;
      end else begin
         pin_role           <= next_role;
         pin_convert        <= next_conv;
         gain_amp_convert   <= next_gain_conv;
         pin_prohibited     <= next_prohib;
         setting_prohibited <= |next_prohib;
      end
   end

   // write happens once address and data are both held and no response pending
   assign wr_fire   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_mapped = (~|wr_addr[ADDR_W-1:5]) && ({3'b000, wr_addr[4:0]} <= `ADCPF_OFF_CHSEL);
   assign rd_mapped = ~|s_axi_araddr[ADDR_W-1:5];

   // write channels: address and data accepted in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `ADCPF_RESP_OKAY;
         wr_addr       <= {ADDR_W{1'b0}};
         wr_data       <= 32'h0;
         wr_strb       <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            wr_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wr_data      <= s_axi_wdata;
            wr_strb      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `ADCPF_RESP_OKAY : `ADCPF_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // control register updates, low byte lane only
   always @(posedge aclk) begin
      if (!aresetn) begin
         analog_config_reg_0      <= `ADCPF_RST_CFG0;
         analog_config_reg_1      <= `ADCPF_RST_CFG1;
         port2_direction_reg      <= `ADCPF_RST_P2DIR;
         port7_direction_reg      <= `ADCPF_RST_P7DIR;
         opamp0_enable            <= 1'b0;
         gain_amp_enable          <= 1'b0;
         converter_channel_select <= `ADCPF_RST_CHSEL;
      end else if (wr_fire && wr_strb[0] && ~|wr_addr[ADDR_W-1:5]) begin
         case ({3'b000, wr_addr[4:0]})
            `ADCPF_OFF_CFG0:   analog_config_reg_0 <= wr_data[7:0];
            `ADCPF_OFF_CFG1:   analog_config_reg_1 <= wr_data[2:0];
            `ADCPF_OFF_P2DIR:  port2_direction_reg <= wr_data[7:0];
            `ADCPF_OFF_P7DIR:  port7_direction_reg <= wr_data[2:0];
            `ADCPF_OFF_OPAMP0: begin
               opamp0_enable   <= wr_data[`ADCPF_BIT_OPAMP0_EN];
               gain_amp_enable <= wr_data[`ADCPF_BIT_GAIN_EN];
            end
            `ADCPF_OFF_CHSEL:  converter_channel_select <= wr_data[4:0];
            default: ;
         endcase
      end
   end

   // status word: conversion flags, gain flag, prohibited summary and per pin
   assign status_word = {12'h000, pin_prohibited, setting_prohibited, gain_amp_convert, pin_convert};

   // read data mux
   always @* begin
      rd_word = 32'h0;
      case ({3'b000, s_axi_araddr[4:0]})
         `ADCPF_OFF_CFG0:   rd_word = {24'h0, analog_config_reg_0};
         `ADCPF_OFF_CFG1:   rd_word = {29'h0, analog_config_reg_1};
         `ADCPF_OFF_P2DIR:  rd_word = {24'h0, port2_direction_reg};
         `ADCPF_OFF_P7DIR:  rd_word = {29'h0, port7_direction_reg};
         `ADCPF_OFF_OPAMP0: rd_word = {24'h0, opamp0_enable, gain_amp_enable, 6'h00};
         `ADCPF_OFF_CHSEL:  rd_word = {27'h0, converter_channel_select};
         `ADCPF_OFF_ROLE:   rd_word = {5'h00, pin_role};
         `ADCPF_OFF_STATUS: rd_word = status_word;
         default:           rd_word = 32'h0;
      endcase
      if (!rd_mapped)
         rd_word = 32'h0;
   end

   // read channel: one read at a time, answer the cycle after acceptance
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `ADCPF_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_mapped ? `ADCPF_RESP_OKAY : `ADCPF_RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // adcpf_top

//--- bench/adcpf_monitor.sv
`timescale 1ns/1ps
`include "adcpf_consts.vh"
module adcpf_monitor (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [26:0] pin_role,
   input wire [8:0]  pin_convert,
   input wire        gain_amp_convert,
   input wire [8:0]  pin_prohibited,
   input wire        setting_prohibited
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // slots whose role code says prohibited
   function automatic logic [8:0] role_bad(input logic [26:0] r);
      for (int k = 0; k < 9; k++) role_bad[k] = (r[3*k +: 3] == `ADCPF_ROLE_PROHIBIT);
   endfunction
   // bus answers and holds
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer missing");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer missing");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read answer dropped");
   // pin status consistency
   a_prohib_any: assert property (setting_prohibited == |pin_prohibited)
      else $error("summary flag wrong");
   a_prohib_role: assert property (pin_prohibited == role_bad(pin_role))
      else $error("prohibited flags disagree with roles");
   a_conv_clean: assert property ((pin_convert & pin_prohibited) == 9'h000)
      else $error("prohibited slot converted");
   a_conv_single: assert property ($onehot0({gain_amp_convert, pin_convert}))
      else $error("two conversions at once");
   a_gain_role: assert property (gain_amp_convert |-> pin_role[2:0] == `ADCPF_ROLE_GAIN_IN
                                 || pin_role[2:0] == `ADCPF_ROLE_OPAMP_GAIN)
      else $error("gain conversion without gain input");
   c_prohib: cover property (setting_prohibited);
   c_gain: cover property (gain_amp_convert);
   c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule // adcpf_monitor

bind adcpf_top adcpf_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .pin_role(pin_role), .pin_convert(pin_convert), .gain_amp_convert(gain_amp_convert),
   .pin_prohibited(pin_prohibited), .setting_prohibited(setting_prohibited));

//--- bench/adc_pin_function_decode_tb_top.sv
`timescale 1ns/1ps
`include "adcpf_consts.vh"
module adc_pin_function_decode_tb_top;
   logic        aclk = 0, aresetn = 0;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, d;
   logic [1:0]  r;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   wire         awready, wready, bvalid, arready, rvalid, gconv, sprohib;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [26:0] role;
   wire  [8:0]  conv, prohib;
   logic [7:0]  rv [6], cur [6];
   logic [7:0]  msk [6] = '{8'hff, 8'h07, 8'hff, 8'h07, 8'hc0, 8'h1f};
   int          err_count = 0, total_checks = 0;

   always #12.5 aclk = ~aclk;

   adcpf_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pin_role(role), .pin_convert(conv), .gain_amp_convert(gconv),
      .pin_prohibited(prohib), .setting_prohibited(sprohib));

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t word got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_pins(input logic [46:0] got, input logic [46:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t pins got %h exp %h", $time, got, exp);
      end
   endtask

   // one clock with a bounded wait
   task automatic tick(inout int n);
      @(posedge aclk);
      if (++n > 50) begin
         err_count++;
         $display("ERROR %0t bus timeout", $time);
         give_verdict();
      end
   endtask

   // bus write, answer taken late at random
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      int n = 0;
      int dly = $urandom % 4;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1;
      wvalid <= 1;
      do begin
         tick(n);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (n > dly && !bready) bready <= 1;
      end while (!(bvalid && bready));
      resp = bresp;
      bready <= 0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      int n = 0;
      int dly = $urandom % 4;
      araddr <= a;
      arvalid <= 1;
      do begin
         tick(n);
         if (arvalid && arready) arvalid <= 0;
         if (n > dly && !rready) rready <= 1;
      end while (!(rvalid && rready));
      v = rdata;
      resp = rresp;
      rready <= 0;
   endtask

   // expected {prohibited, any, gain conv, conv, roles} from register copies
   function automatic logic [46:0] exp_pins();
      logic [26:0] ro = 0;
      logic [8:0]  cv = 0, ph = 0;
      logic        gc, an, di, sel;
      logic [2:0]  c;
      for (int k = 0; k < 9; k++) begin
         sel = cur[5][4:0] == (k == 0 ? 5'd1 : 5'(k + 2));
         an = k == 0 ? cur[0][1] : k < 6 ? cur[0][k + 2] : !cur[1][k - 6];
         di = k == 0 ? cur[2][1] : k < 6 ? cur[2][k + 2] : cur[3][k - 6];
         if (an) c = di ? 3'h2 : 3'h7;
         else c = (sel || (k == 0 && cur[4][7])) ? 3'h7 : {2'h0, !di};
         if (k == 0 && an && di) c = 3'h2 + {2'h0, cur[4][6]} + {1'b0, cur[4][7], 1'b0};
         ro[3*k +: 3] = c;
         ph[k] = c == 3'h7;
         cv[k] = sel && !ph[k];
      end
      gc = cur[0][1] && cur[2][1] && cur[4][6] && cur[5][4:0] == 5'h10;
      return {ph, |ph, gc, cv, ro};
   endfunction

   // write every register, pins follow one edge after the write response
   task automatic write_all();
      logic [31:0] v;
      for (int i = 0; i < 6; i++) begin
         v = $urandom;
         v[7:0] = rv[i] | (v[7:0] & ~msk[i]);
         wr(8'(4 * i), v, r);
         cur[i] = rv[i];
         chk_word({30'h0, r}, {30'h0, `ADCPF_RESP_OKAY});
         @(posedge aclk);
         chk_pins({prohib, sprohib, gconv, conv, role}, exp_pins());
      end
   endtask

   task automatic read_all();
      logic [46:0] e;
      e = exp_pins();
      chk_pins({prohib, sprohib, gconv, conv, role}, e);
      for (int i = 0; i < 6; i++) begin
         rd(8'(4 * i), d, r);
         chk_word(d, {24'h0, cur[i]});
      end
      rd(`ADCPF_OFF_ROLE, d, r);
      chk_word(d, {5'h0, e[26:0]});
      rd(`ADCPF_OFF_STATUS, d, r);
      chk_word(d, {12'h0, e[46:27]});
   endtask

   initial begin
      void'($urandom(28410));
      rv = '{8'h00, 8'h07, 8'hff, 8'h07, 8'h00, 8'h00};
      cur = rv;
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
      read_all();
      $display("test reset done");
      // shared pin as analog input, every amplifier mode with channels 1, 0x10 and 0
      for (int m = 0; m < 12; m++) begin
         foreach (rv[i]) rv[i] = 8'($urandom) & msk[i];
         rv[0] = rv[0] | 8'h02;
         rv[2] = rv[2] | 8'h02;
         rv[4] = 8'((m % 4) << 6);
         rv[5] = m < 4 ? 8'h01 : m < 8 ? 8'h10 : 8'h00;
         write_all();
         read_all();
      end
      $display("test shared pin done");
      // random settings, channel often a live one
      for (int t = 0; t < 40; t++) begin
         foreach (rv[i]) rv[i] = 8'($urandom) & msk[i];
         if (t % 2) rv[5] = ($urandom % 3 == 0) ? 8'h10 : 8'($urandom % 11);
         write_all();
         read_all();
      end
      $display("test random done");
      // read-only and unmapped places refuse writes
      wr(`ADCPF_OFF_ROLE, 32'hffffffff, r);
      chk_word({30'h0, r}, {30'h0, `ADCPF_RESP_SLVERR});
      wr(8'h20, 32'hffffffff, r);
      chk_word({30'h0, r}, {30'h0, `ADCPF_RESP_SLVERR});
      rd(8'h24, d, r);
      chk_word({d[29:0], r}, {30'h0, `ADCPF_RESP_SLVERR});
      read_all();
      $display("test unmapped done");
      give_verdict();
   end
endmodule // adc_pin_function_decode_tb_top
